// ---- rtl/rscl_top.sv ----
// rscl_top.sv: captures configuration straps when hard reset releases
// assumes: pins synchronous to clock; hard_reset_n is a synchronous level input
`timescale 1ns/1ps
`include "rscl_consts.svh"
// Operation
// - pins act as inputs during hard reset
// - latch pin levels when hard reset releases
// - after the hold cycles, receiver off, pins drive outputs
// - pull-up on during reset plus hold cycles
// - pull-up turns off with the receiver
// - high captured timestamp levels select sync default setting
// - timestamp straps decode memory clock ratio
// - platform clock ratio is 4,5,6,8,10,12
module rscl_top (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic hard_reset_n,
  input wire logic [`RSCL_STRAP_W-1:0] strap_in,
  input wire logic [`RSCL_STRAP_W-1:0] func_out,
  output logic [`RSCL_STRAP_W-1:0] strap_out,
  output logic [`RSCL_STRAP_W-1:0] strap_oe_n,
  output logic rx_enable,
  output logic pullup_en,
  output logic config_valid,
  output rscl_pkg::rscl_mem_ratio_t mem_ratio,
  output logic [`RSCL_PR_W-1:0] platform_ratio,
  output logic platform_ratio_ok
);
  rscl_strap_if sif ();
  rscl_pkg::rscl_state_t state_q;
  rscl_pkg::rscl_state_t state_d;
  logic [`RSCL_CNT_W-1:0] cnt_q;
  logic [`RSCL_CNT_W-1:0] cnt_d;
  logic [`RSCL_STRAP_W-1:0] out_q;
  logic [`RSCL_STRAP_W-1:0] out_d;
  logic hr_q;
  logic [`RSCL_TS_W-1:0] ts_bits;
  rscl_pkg::rscl_mem_ratio_t mem_ratio_q;
  rscl_pkg::rscl_mem_ratio_t mem_ratio_d;
  logic ratio_ok_q;
  logic ratio_ok_d;

  // --------------------------------
  // capture sequencer
  // --------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      rscl_pkg::RSCL_IN_RESET: begin
        cnt_d = '0;
        if (hard_reset_n) begin
          state_d = rscl_pkg::RSCL_HOLD;
        end
      end
      rscl_pkg::RSCL_HOLD: begin
        cnt_d = cnt_q + `RSCL_CNT_W'(1);
        if (!hard_reset_n) begin
          state_d = rscl_pkg::RSCL_IN_RESET;
        end else if (cnt_q == `RSCL_HOLD_CYC - `RSCL_CNT_W'(1)) begin
          state_d = rscl_pkg::RSCL_RUN;
        end
      end
      rscl_pkg::RSCL_RUN: begin
        if (!hard_reset_n) begin
          state_d = rscl_pkg::RSCL_IN_RESET;
        end
      end
      default: begin
        state_d = rscl_pkg::RSCL_IN_RESET;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= rscl_pkg::RSCL_IN_RESET;
      cnt_q <= '0;
      hr_q <= 1'b0;
      out_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      hr_q <= hard_reset_n;
      out_q <= out_d;
    end
  end

  // --------------------------------
  // capture pulse on release
  // --------------------------------
  assign sif.capture = clk_en && hard_reset_n && !hr_q;
  assign sif.pin_level = strap_in;

  rscl_strap_reg u_reg (
    .clock(clock),
    .nrst(nrst),
    .clk_en(clk_en),
    .sif(sif)
  );

  // --------------------------------
  // pad control
  // --------------------------------
  assign rx_enable = (state_q != rscl_pkg::RSCL_RUN);
  assign pullup_en = rx_enable;
  assign strap_oe_n = rx_enable ? '1 : '0;
  assign config_valid = (state_q == rscl_pkg::RSCL_RUN);

  always_comb begin
    out_d = (state_d == rscl_pkg::RSCL_RUN) ? func_out : '0;
  end
  assign strap_out = out_q;

  // --------------------------------
  // ratio decode
  // --------------------------------
  assign ts_bits = sif.captured[`RSCL_TS_LSB +: `RSCL_TS_W];
  assign platform_ratio = sif.captured[`RSCL_PR_LSB +: `RSCL_PR_W];

  always_comb begin
    case (ts_bits)
      `RSCL_MEM_12: mem_ratio_d = rscl_pkg::RSCL_MEM_RATIO_12;
      `RSCL_MEM_14: mem_ratio_d = rscl_pkg::RSCL_MEM_RATIO_14;
      `RSCL_MEM_SYNC: mem_ratio_d = rscl_pkg::RSCL_MEM_RATIO_SYNC;
      default: mem_ratio_d = rscl_pkg::RSCL_MEM_RATIO_BAD;
    endcase
  end

  always_comb begin
    case (platform_ratio)
      4'h4, 4'h5, 4'h6, 4'h8, 4'hA, 4'hC: ratio_ok_d = 1'b1;
      default: ratio_ok_d = 1'b0;
    endcase
  end

  // decoded settings on flops, one cycle behind capture
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mem_ratio_q <= rscl_pkg::RSCL_MEM_RATIO_SYNC;
      ratio_ok_q <= 1'b0;
    end else if (clk_en) begin
      mem_ratio_q <= mem_ratio_d;
      ratio_ok_q <= ratio_ok_d;
    end
  end

  assign mem_ratio = mem_ratio_q;
  assign platform_ratio_ok = ratio_ok_q;

  // --------------------------------
  // checks
  // --------------------------------
  AST_PINS_IN_RESET: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && !hard_reset_n |=> rx_enable && strap_oe_n == '1)
    else $error("pins not inputs in reset");
  AST_ABORT_HOLD: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && !hard_reset_n && state_q == rscl_pkg::RSCL_HOLD
    |=> state_q == rscl_pkg::RSCL_IN_RESET)
    else $error("hold not abandoned on hard reset");
  AST_OUT_QUIET: assert property (@(posedge clock) disable iff (!nrst)
    !config_valid |-> strap_out == '0)
    else $error("pin data driven before capture done");
  AST_CAPTURE_VALUE: assert property (@(posedge clock) disable iff (!nrst)
    sif.capture |=> sif.captured == $past(strap_in))
    else $error("strap not captured");
  AST_HOLD_ENTRY: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && hard_reset_n && state_q == rscl_pkg::RSCL_IN_RESET
    |=> state_q == rscl_pkg::RSCL_HOLD)
    else $error("release did not start the hold");
  AST_HOLD_LEN: assert property (@(posedge clock) disable iff (!nrst)
    (clk_en && hard_reset_n && state_q == rscl_pkg::RSCL_IN_RESET)
    ##1 (clk_en && hard_reset_n) [*4] |=> pullup_en == 1'b0)
    else $error("pull-up not released after hold");
  AST_HOLD_MIN: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && hard_reset_n && state_q == rscl_pkg::RSCL_IN_RESET |=> pullup_en [*4])
    else $error("pull-up released too early");
  AST_CNT_RANGE: assert property (@(posedge clock) disable iff (!nrst)
    state_q == rscl_pkg::RSCL_HOLD |-> cnt_q < `RSCL_HOLD_CYC)
    else $error("hold counter out of range");
  AST_PULL_WITH_RX: assert property (@(posedge clock) disable iff (!nrst)
    pullup_en == rx_enable)
    else $error("pull-up and receiver differ");
  AST_RUN_DRIVES: assert property (@(posedge clock) disable iff (!nrst)
    !rx_enable |-> strap_oe_n == '0)
    else $error("pins not driven after capture");
  AST_OUT_FOLLOWS: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && config_valid && hard_reset_n |=> strap_out == $past(func_out))
    else $error("pin data does not follow function");
  AST_SYNC_DEFAULT: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && ts_bits == 3'h7 |=> mem_ratio == rscl_pkg::RSCL_MEM_RATIO_SYNC)
    else $error("bad default");
  AST_MEM_12: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && ts_bits == 3'h5 |=> mem_ratio == rscl_pkg::RSCL_MEM_RATIO_12)
    else $error("pattern 101 not decoded");
  AST_MEM_14: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && ts_bits == 3'h6 |=> mem_ratio == rscl_pkg::RSCL_MEM_RATIO_14)
    else $error("pattern 110 not decoded");
  AST_MEM_BAD: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && ts_bits < 3'h5 |=> mem_ratio == rscl_pkg::RSCL_MEM_RATIO_BAD)
    else $error("undefined pattern accepted");
  AST_RATIO_SET: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && platform_ratio == 4'h7 |=> !platform_ratio_ok)
    else $error("ratio 7 accepted");
  AST_RATIO_OK: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && platform_ratio inside {4'h4, 4'h5, 4'h6, 4'h8, 4'hA, 4'hC}
    |=> platform_ratio_ok)
    else $error("supported ratio rejected");
  AST_FROZEN: assert property (@(posedge clock) disable iff (!nrst)
    config_valid && hard_reset_n |=> $stable(sif.captured))
    else $error("config moved");
  AST_NO_RECAPTURE: assert property (@(posedge clock) disable iff (!nrst)
    config_valid |-> !sif.capture)
    else $error("capture while running");
  AST_FREEZE: assert property (@(posedge clock) disable iff (!nrst)
    !clk_en |=> $stable(state_q) && $stable(cnt_q) && $stable(sif.captured)
    && $stable(strap_out))
    else $error("state moved with clock enable low");

  // --------------------------------
  // coverage
  // --------------------------------
  COV_RELEASE: cover property (@(posedge clock) sif.capture);
  COV_RUN: cover property (@(posedge clock) $rose(config_valid));
  COV_RE_RESET: cover property (@(posedge clock) config_valid ##1 !hard_reset_n);
  COV_MEM14: cover property (@(posedge clock)
    config_valid && mem_ratio == rscl_pkg::RSCL_MEM_RATIO_14);
  COV_HOLD_ABORT: cover property (@(posedge clock)
    state_q == rscl_pkg::RSCL_HOLD ##1 state_q == rscl_pkg::RSCL_IN_RESET);
endmodule : rscl_top

// ---- rtl/rscl_consts.svh ----
// rscl_consts.svh: offsets, field positions, reset values and counts for the strap latch
// assumes: included by bare name from rtl/ files
`ifndef RSCL_CONSTS_SVH
`define RSCL_CONSTS_SVH

`define RSCL_TS_W 3
`define RSCL_PR_W 4
`define RSCL_STRAP_W 7
`define RSCL_TS_LSB 0
`define RSCL_PR_LSB 3
`define RSCL_STRAP_RST 7'h7F
`define RSCL_HOLD_CYC 4'h4
`define RSCL_CNT_W 4
`define RSCL_MEM_12 3'h5
`define RSCL_MEM_14 3'h6
`define RSCL_MEM_SYNC 3'h7

`endif

// ---- rtl/rscl_pkg.sv ----
// rscl_pkg.sv: types for the strap latch
// assumes: the constants header is compiled alongside
package rscl_pkg;
  typedef enum logic [1:0] {
    RSCL_MEM_RATIO_12,
    RSCL_MEM_RATIO_14,
    RSCL_MEM_RATIO_SYNC,
    RSCL_MEM_RATIO_BAD
  } rscl_mem_ratio_t;
  typedef enum logic [1:0] {
    RSCL_IN_RESET,
    RSCL_HOLD,
    RSCL_RUN
  } rscl_state_t;
endpackage : rscl_pkg

// ---- rtl/rscl_strap_if.sv ----
// rscl_strap_if.sv: carries the strap capture signals between top and latch
// assumes: one clock, same domain as the top module
`timescale 1ns/1ps
`include "rscl_consts.svh"
interface rscl_strap_if;
  logic capture;
  logic [`RSCL_STRAP_W-1:0] pin_level;
  logic [`RSCL_STRAP_W-1:0] captured;
  modport ctrl (output capture, output pin_level, input captured);
  modport latch (input capture, input pin_level, output captured);
endinterface : rscl_strap_if

// ---- rtl/rscl_strap_reg.sv ----
// rscl_strap_reg.sv: holds the captured strap levels
// assumes: capture is a one-cycle pulse from the controller
`timescale 1ns/1ps
`include "rscl_consts.svh"
module rscl_strap_reg (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  rscl_strap_if.latch sif
);
  logic [`RSCL_STRAP_W-1:0] val_q;
  logic [`RSCL_STRAP_W-1:0] val_d;

  // --------------------------------
  // capture register
  // --------------------------------
  always_comb begin
    val_d = val_q;
    if (sif.capture) begin
      val_d = sif.pin_level;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      val_q <= `RSCL_STRAP_RST;
    end else if (clk_en) begin
      val_q <= val_d;
    end
  end

  assign sif.captured = val_q;

  AST_HOLD_STABLE: assert property (@(posedge clock) disable iff (!nrst)
    !sif.capture |=> val_q == $past(val_q))
    else $error("strap value changed without capture");
endmodule : rscl_strap_reg

// ---- verification/rscl_board.sv ----
// rscl_board.sv: board straps and pad wire for the strap latch
// assumes: pull_dn bit high means a strap resistor to ground
`timescale 1ns/1ps
module rscl_board (
  input wire logic [6:0] pull_dn,
  input wire logic [6:0] oe_n,
  input wire logic [6:0] dout,
  input wire logic pullup_en,
  output logic [6:0] pad
);
  // ----------------------------------------
  // pad level per bit
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (!oe_n[i]) pad[i] = dout[i];
      else if (pull_dn[i]) pad[i] = 1'b0;
      else if (pullup_en) pad[i] = 1'b1;
      else pad[i] = ~dout[i];
    end
  end
endmodule : rscl_board

// ---- verification/rscl_top_tb.sv ----
// rscl_top_tb.sv: self-checking bench for the strap latch
// assumes: design files compiled first
`timescale 1ns/1ps
`include "rscl_consts.svh"
module rscl_top_tb;
  logic clock = 0, nrst = 0, clk_en = 1, hard_reset_n = 0;
  logic [6:0] pull_dn = 0, func_out = 0, pad, strap_out, strap_oe_n;
  logic rx_enable, pullup_en, config_valid, platform_ratio_ok;
  rscl_pkg::rscl_mem_ratio_t mem_ratio;
  logic [3:0] platform_ratio;
  int error_cnt = 0, checked = 0;
  logic [6:0] pats [9] = '{7'h7F, 7'h25, 7'h2E, 7'h37, 7'h40, 7'h55, 7'h66, 7'h1F, 7'h04};
  rscl_board board_u (.pull_dn(pull_dn), .oe_n(strap_oe_n), .dout(strap_out),
    .pullup_en(pullup_en), .pad(pad));
  rscl_top dut_u (.clock(clock), .nrst(nrst), .clk_en(clk_en),
    .hard_reset_n(hard_reset_n), .strap_in(pad), .func_out(func_out),
    .strap_out(strap_out), .strap_oe_n(strap_oe_n), .rx_enable(rx_enable),
    .pullup_en(pullup_en), .config_valid(config_valid), .mem_ratio(mem_ratio),
    .platform_ratio(platform_ratio), .platform_ratio_ok(platform_ratio_ok));
  always #50 clock = ~clock;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task wrap_up;
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // ----------------------------------------
  // one strap capture and its checks
  // ----------------------------------------
  task run_strap(input logic [6:0] s);
    logic [1:0] em;
    em = (s[2:0] == 3'h5) ? 2'h0 : (s[2:0] == 3'h6) ? 2'h1 : (s[2:0] == 3'h7) ? 2'h2 : 2'h3;
    hard_reset_n = 0;
    pull_dn = ~s;
    cyc(2);
    chk({rx_enable, pullup_en, config_valid}, 8'h06);
    chk(strap_oe_n, 8'h7F);
    chk(strap_out, 8'h00);
    hard_reset_n = 1;
    cyc(4);
    chk({rx_enable, pullup_en, config_valid}, 8'h06);
    chk(platform_ratio, s[6:3]);
    chk(mem_ratio, em);
    chk(platform_ratio_ok, s[6:3] inside {4, 5, 6, 8, 10, 12});
    cyc(1);
    chk({rx_enable, pullup_en, config_valid}, 8'h01);
    chk(strap_oe_n, 8'h00);
    func_out = ~s;
    cyc(2);
    chk(strap_out, {1'b0, ~s});
    chk(platform_ratio, s[6:3]);
    chk(mem_ratio, em);
  endtask : run_strap
  // ----------------------------------------
  // release cut short by a new hard reset
  // ----------------------------------------
  task run_abort(input logic [6:0] s);
    hard_reset_n = 0;
    pull_dn = ~s;
    cyc(2);
    hard_reset_n = 1;
    cyc(2);
    hard_reset_n = 0;
    cyc(1);
    chk({rx_enable, pullup_en, config_valid}, 8'h06);
    cyc(5);
    chk({rx_enable, pullup_en, config_valid}, 8'h06);
    chk(platform_ratio, s[6:3]);
  endtask : run_abort
  // ----------------------------------------
  // clock enable dropped during the hold
  // ----------------------------------------
  task run_pause(input logic [6:0] s);
    hard_reset_n = 0;
    pull_dn = ~s;
    cyc(2);
    hard_reset_n = 1;
    cyc(2);
    clk_en = 0;
    pull_dn = s;
    cyc(6);
    chk({rx_enable, pullup_en, config_valid}, 8'h06);
    clk_en = 1;
    cyc(3);
    chk({rx_enable, pullup_en, config_valid}, 8'h01);
    chk(platform_ratio, s[6:3]);
  endtask : run_pause
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(20);
    nrst = 1;
    cyc(2);
    foreach (pats[i]) run_strap(pats[i]);
    run_abort(7'h2D);
    run_strap(7'h36);
    run_pause(7'h55);
    wrap_up();
  end
endmodule : rscl_top_tb
